// [hw/cal_sync.sv]
// Two-stage synchroniser for the calendar inputs.
`timescale 1ns/1ps

module cal_sync (
	// Clock and reset.
	input  wire logic           clk,
	input  wire logic           srst,
	// Raw and synchronised calendar.
	input  wire sched_pkg::cal_t d,
	output sched_pkg::cal_t      q
);
	import sched_pkg::*;

	// The fields are synchronised bit by bit, so a multi-bit change may show one
	// mixed value for a cycle; the calendar source changes far slower than that.
	logic [CAL_W-1:0] raw;
	logic [CAL_W-1:0] meta_r;
	logic [CAL_W-1:0] stab_r;

	assign raw = d;
	assign q   = stab_r;

	for (genvar i = 0; i < CAL_W; i++) begin : g_bit
		logic meta_nxt;
		logic stab_nxt;

		always_comb begin
			meta_nxt = srst ? 1'b0 : raw[i];
			stab_nxt = srst ? 1'b0 : meta_r[i];
		end

		always_ff @(posedge clk) begin
			meta_r[i] <= meta_nxt;
			stab_r[i] <= stab_nxt;
		end
	end

endmodule // cal_sync

// [hw/calendar_timer_qualifier.sv]
// Top of the calendar timer qualifier: AXI4-Lite registers and the active flag.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module calendar_timer_qualifier (
	// Clock and reset.
	input  wire logic                 clk,
	input  wire logic                 srst,
	// AXI4-Lite register bus.
	input  wire sched_pkg::axil_req_t axil_i,
	output sched_pkg::axil_rsp_t      axil_o,
	// Calendar pins from the clock source.
	input  wire sched_pkg::cal_t      cal_i,
	// Timer decision.
	output logic                      timer_active
);
	import sched_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Calendar capture and decision.
	cal_t        cal_s;
	logic        qual_active;
	logic        active_r;
	logic        active_nxt;
	logic [15:0] cfg_r;
	logic [15:0] cfg_nxt;

	cal_sync u_sync (
		.clk  (clk),
		.srst (srst),
		.d    (cal_i),
		.q    (cal_s)
	);

	sched_qualify u_qual (
		.cfg    (cfg_r),
		.cal    (cal_s),
		.active (qual_active)
	);

	always_comb begin
		active_nxt = srst ? 1'b0 : qual_active;
	end

	always_ff @(posedge clk) begin
		active_r <= active_nxt;
	end

	assign timer_active = active_r;

	////////////////////////////////////////////////////////////////////////////////
	// Write channels. Address and data are held separately so either may come
	// first; a new pair is refused until the response has been taken.
	logic        aw_held_r;
	logic        aw_held_nxt;
	logic [31:0] awaddr_r;
	logic [31:0] awaddr_nxt;
	logic        w_held_r;
	logic        w_held_nxt;
	logic [31:0] wdata_r;
	logic [31:0] wdata_nxt;
	logic [3:0]  wstrb_r;
	logic [3:0]  wstrb_nxt;
	logic        bvalid_r;
	logic        bvalid_nxt;
	logic [1:0]  bresp_r;
	logic [1:0]  bresp_nxt;
	logic        awready_c;
	logic        wready_c;

	always_comb begin
		awready_c   = !aw_held_r && !bvalid_r;
		wready_c    = !w_held_r && !bvalid_r;
		aw_held_nxt = aw_held_r;
		awaddr_nxt  = awaddr_r;
		w_held_nxt  = w_held_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		cfg_nxt     = cfg_r;
		if (axil_i.awvalid && awready_c) begin
			aw_held_nxt = 1'b1;
			awaddr_nxt  = axil_i.awaddr;
		end
		if (axil_i.wvalid && wready_c) begin
			w_held_nxt = 1'b1;
			wdata_nxt  = axil_i.wdata;
			wstrb_nxt  = axil_i.wstrb;
		end
		if (bvalid_r && axil_i.bready) begin
			bvalid_nxt = 1'b0;
		end
		if (aw_held_r && w_held_r) begin
			aw_held_nxt = 1'b0;
			w_held_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = RESP_OKAY;
			if (awaddr_r == ADDR_CONFIG) begin
				// All sixteen bits are stored, reserved ones included.
				if (wstrb_r[0]) begin
					cfg_nxt[7:0] = wdata_r[7:0];
				end
				if (wstrb_r[1]) begin
					cfg_nxt[15:8] = wdata_r[15:8];
				end
			end else if (awaddr_r != ADDR_STATUS) begin
				bresp_nxt = RESP_SLVERR;
			end
		end
		if (srst) begin
			aw_held_nxt = 1'b0;
			awaddr_nxt  = 32'h0000_0000;
			w_held_nxt  = 1'b0;
			wdata_nxt   = 32'h0000_0000;
			wstrb_nxt   = 4'h0;
			bvalid_nxt  = 1'b0;
			bresp_nxt   = RESP_OKAY;
			cfg_nxt     = CFG_RST;
		end
	end

	always_ff @(posedge clk) begin
		aw_held_r <= aw_held_nxt;
		awaddr_r  <= awaddr_nxt;
		w_held_r  <= w_held_nxt;
		wdata_r   <= wdata_nxt;
		wstrb_r   <= wstrb_nxt;
		bvalid_r  <= bvalid_nxt;
		bresp_r   <= bresp_nxt;
		cfg_r     <= cfg_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read channel.
	logic        rvalid_r;
	logic        rvalid_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [1:0]  rresp_r;
	logic [1:0]  rresp_nxt;
	logic        arready_c;
	logic [31:0] status_word;

	always_comb begin
		arready_c   = !rvalid_r;
		status_word = 32'h0000_0000;
		status_word[ST_ACTIVE] = active_r;
		status_word[ST_CAL_LSB +: CAL_W] = cal_s;
		rvalid_nxt  = rvalid_r;
		rdata_nxt   = rdata_r;
		rresp_nxt   = rresp_r;
		if (rvalid_r && axil_i.rready) begin
			rvalid_nxt = 1'b0;
		end
		if (axil_i.arvalid && arready_c) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = RESP_OKAY;
			if (axil_i.araddr == ADDR_CONFIG) begin
				rdata_nxt = {16'h0000, cfg_r};
			end else if (axil_i.araddr == ADDR_STATUS) begin
				rdata_nxt = status_word;
			end else begin
				rdata_nxt = 32'h0000_0000;
				rresp_nxt = RESP_SLVERR;
			end
		end
		if (srst) begin
			rvalid_nxt = 1'b0;
			rdata_nxt  = 32'h0000_0000;
			rresp_nxt  = RESP_OKAY;
		end
	end

	always_ff @(posedge clk) begin
		rvalid_r <= rvalid_nxt;
		rdata_r  <= rdata_nxt;
		rresp_r  <= rresp_nxt;
	end

	always_comb begin
		axil_o         = '0;
		axil_o.awready = awready_c;
		axil_o.wready  = wready_c;
		axil_o.bvalid  = bvalid_r;
		axil_o.bresp   = bresp_r;
		axil_o.arready = arready_c;
		axil_o.rvalid  = rvalid_r;
		axil_o.rdata   = rdata_r;
		axil_o.rresp   = rresp_r;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks. The helpers rebuild the decision terms independently of u_qual.
	logic h_day_ok;
	logic h_season_ok;
	logic h_exc;
	logic h_norm;
	logic h_weekend;

	always_comb begin
		h_day_ok    = (cal_s.weekday < NUM_DAYS) && cfg_r[cal_s.weekday];
		h_season_ok = cfg_r[CFG_SEASON_LSB + int'(cal_s.season)];
		h_exc       = cal_s.holiday || cal_s.workday;
		h_norm      = h_day_ok && h_season_ok && cal_s.in_window;
		h_weekend   = (cal_s.weekday == 3'h5) || (cal_s.weekday == 3'h6);
	end

	default clocking cb @(posedge clk);
	endclocking

	default disable iff (srst);

	chk_weekday_block: assert property (
		(cal_s.weekday < 3'h5) && !cfg_r[cal_s.weekday] && !cfg_r[CFG_EXC_EN]
		|=> !timer_active)
		else $error("Disabled weekday let the timer run.");

	chk_weekend_enable: assert property (
		h_weekend && h_day_ok && h_season_ok && cal_s.in_window && !h_exc
		|=> timer_active)
		else $error("Enabled weekend day did not run the timer.");

	chk_season_block: assert property (
		!h_season_ok && (!cfg_r[CFG_EXC_EN] || !h_exc) |=> !timer_active)
		else $error("Disabled season let the timer run.");

	chk_exc_off_plain: assert property (
		!cfg_r[CFG_EXC_EN] |=> (timer_active == $past(h_norm)))
		else $error("Exception handling off but result differs from plain.");

	chk_exc_on_normal: assert property (
		(cfg_r[CFG_EXC_EN] && !h_exc && h_norm) [*2]
		|=> timer_active && $past(timer_active))
		else $error("Normal day dropped while exceptions enabled.");

	chk_exc_none_sel: assert property (
		cfg_r[CFG_EXC_EN] && !cfg_r[CFG_HOL_SEL] && !cfg_r[CFG_WRK_SEL] && h_exc
		|=> !timer_active)
		else $error("Timer ran on exception day with no selection.");

	chk_holiday_gated: assert property (
		!cfg_r[CFG_EXC_EN] && cal_s.holiday && !h_norm |=> !timer_active)
		else $error("Holiday bit acted without exception enable.");

	chk_holiday_run: assert property (
		cfg_r[CFG_EXC_EN] && cfg_r[CFG_HOL_SEL] && cal_s.holiday && cal_s.in_window
		|=> timer_active)
		else $error("Selected holiday in window did not run the timer.");

	chk_workday_gated: assert property (
		!cfg_r[CFG_EXC_EN] && cal_s.workday && !h_norm |=> !timer_active)
		else $error("Workday bit acted without exception enable.");

	chk_workday_run: assert property (
		cfg_r[CFG_EXC_EN] && cfg_r[CFG_WRK_SEL] && cal_s.workday && cal_s.in_window
		|=> timer_active)
		else $error("Selected workday in window did not run the timer.");

	chk_exc_ignores_day: assert property (
		cfg_r[CFG_EXC_EN] && h_exc
		|=> (timer_active == ($past(cal_s.in_window) &&
		     (($past(cfg_r[CFG_HOL_SEL]) && $past(cal_s.holiday)) ||
		      ($past(cfg_r[CFG_WRK_SEL]) && $past(cal_s.workday))))))
		else $error("Exception day result used weekday or season bits.");

	chk_reserved_store: assert property (
		aw_held_r && w_held_r && (awaddr_r == ADDR_CONFIG) && wstrb_r[1]
		|=> (cfg_r[15:CFG_RSV_LSB] == $past(wdata_r[15:CFG_RSV_LSB])) ##0 bvalid_r)
		else $error("Reserved config bits not stored as written.");

	chk_bresp_hold: assert property (
		bvalid_r && !axil_i.bready |=> bvalid_r && $stable(bresp_r))
		else $error("Write response dropped before it was taken.");

	chk_read_latency: assert property (
		axil_i.arvalid && arready_c |=> rvalid_r)
		else $error("Read answer did not follow the address by one cycle.");

	chk_season_enable: assert property (
		!cfg_r[CFG_EXC_EN] && h_day_ok && h_season_ok && cal_s.in_window |=> timer_active)
		else $error("Enabled day and season in window did not run the timer.");

	chk_window_gate: assert property (
		!cal_s.in_window |=> !timer_active)
		else $error("Timer ran outside the start and duration window.");

	chk_read_config: assert property (
		axil_i.arvalid && arready_c && (axil_i.araddr == ADDR_CONFIG)
		|=> (axil_o.rdata == {16'h0000, $past(cfg_r)}))
		else $error("Config read did not return the stored word.");

	chk_write_latency: assert property (
		aw_held_r && w_held_r |=> bvalid_r)
		else $error("Write response did not follow the commit by one cycle.");

endmodule // calendar_timer_qualifier

// [hw/sched_pkg.sv]
// Shared constants and carriers for the calendar timer qualifier.
package sched_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Configuration word layout.
	localparam int          CFG_W          = 16;
	localparam logic [15:0] CFG_RST        = 16'h0780;
	localparam int          CFG_DAY_LSB    = 0;
	localparam int          CFG_SEASON_LSB = 7;
	localparam int          CFG_EXC_EN     = 11;
	localparam int          CFG_HOL_SEL    = 12;
	localparam int          CFG_WRK_SEL    = 13;
	localparam int          CFG_RSV_LSB    = 14;
	localparam logic [2:0]  NUM_DAYS       = 3'h7;

	////////////////////////////////////////////////////////////////////////////////
	// Register map and status layout.
	localparam logic [31:0] ADDR_CONFIG    = 32'h0000_0000;
	localparam logic [31:0] ADDR_STATUS    = 32'h0000_0004;
	localparam int          ST_ACTIVE      = 0;
	localparam int          ST_CAL_LSB     = 1;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Calendar inputs: weekday 0 is Monday, 6 is Sunday, 7 is never enabled.
	typedef struct packed {
		logic [2:0] weekday;
		logic [1:0] season;
		logic       holiday;
		logic       workday;
		logic       in_window;
	} cal_t;

	localparam int CAL_W = $bits(cal_t);

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite channels, master to slave and slave to master.
	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_t;

endpackage

// [hw/sched_qualify.sv]
// Decision logic: is the scheduled timer active for this calendar state.
`timescale 1ns/1ps

module sched_qualify (
	// Configuration and calendar.
	input  wire logic [15:0]     cfg,
	input  wire sched_pkg::cal_t cal,
	// Decision.
	output logic                 active
);
	import sched_pkg::*;

	logic [7:0] day_en;
	logic [3:0] season_en;
	logic       day_ok;
	logic       season_ok;
	logic       normal_ok;
	logic       exc_day;
	logic       exc_ok;

	always_comb begin
		// Weekday code 7 lands on the zero pad bit, so the index never runs off the end.
		day_en    = {1'b0, cfg[CFG_DAY_LSB +: 7]};
		season_en = cfg[CFG_SEASON_LSB +: 4];
		day_ok    = (cal.weekday < NUM_DAYS) && day_en[cal.weekday];
		season_ok = season_en[cal.season];
		normal_ok = day_ok && season_ok && cal.in_window;
		exc_day   = cal.holiday || cal.workday;
		exc_ok    = cal.in_window &&
		            ((cfg[CFG_HOL_SEL] && cal.holiday) ||
		             (cfg[CFG_WRK_SEL] && cal.workday));
		// Bits 15:14 take no part in the decision.
		if (!cfg[CFG_EXC_EN]) begin
			active = normal_ok;
		end else if (exc_day) begin
			active = exc_ok;
		end else begin
			active = normal_ok;
		end
	end

endmodule // sched_qualify

// [test/calendar_timer_qualifier_bench.sv]
// Self-checking bench for the calendar timer qualifier.
`timescale 1ns/1ps

module calendar_timer_qualifier_bench;
	import sched_pkg::*;

	logic      clk;
	logic      srst;
	axil_req_t axil_i;
	axil_rsp_t axil_o;
	cal_t      cal_i;
	logic      timer_active;
	int        miscompares;
	int        n_checks;

	calendar_timer_qualifier dut (
		.clk          (clk),
		.srst         (srst),
		.axil_i       (axil_i),
		.axil_o       (axil_o),
		.cal_i        (cal_i),
		.timer_active (timer_active)
	);

	always #10 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check_bit(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Ready is sampled at the falling edge, where it has settled, and the transfer then
	// happens at the next rising edge; this keeps the bench clear of edge races.
	task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
			output logic [1:0] r);
		logic aw;
		logic w;
		logic b;
		axil_i.awvalid <= 1'b1;
		axil_i.awaddr  <= a;
		axil_i.wvalid  <= 1'b1;
		axil_i.wdata   <= d;
		axil_i.wstrb   <= s;
		axil_i.bready  <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge clk);
			aw = axil_i.awvalid && axil_o.awready;
			w  = axil_i.wvalid && axil_o.wready;
			b  = axil_o.bvalid;
			r  = axil_o.bresp;
			@(posedge clk);
			if (aw)
				axil_i.awvalid <= 1'b0;
			if (w)
				axil_i.wvalid <= 1'b0;
		end
		axil_i.bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar;
		logic got;
		axil_i.arvalid <= 1'b1;
		axil_i.araddr  <= a;
		axil_i.rready  <= 1'b1;
		got = 1'b0;
		while (!got) begin
			@(negedge clk);
			ar  = axil_i.arvalid && axil_o.arready;
			got = axil_o.rvalid;
			d   = axil_o.rdata;
			r   = axil_o.rresp;
			@(posedge clk);
			if (ar)
				axil_i.arvalid <= 1'b0;
		end
		axil_i.rready <= 1'b0;
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reference decision, worked out independently of the design.
	function automatic logic model(input logic [15:0] c, input cal_t k);
		if (c[11] && (k.holiday || k.workday))
			return k.in_window && ((c[12] && k.holiday) || (c[13] && k.workday));
		return k.in_window && (k.weekday != 3'h7) && c[k.weekday] && c[7 + k.season];
	endfunction

	task automatic set_cfg(input logic [15:0] c);
		logic [31:0] d;
		logic [1:0]  r;
		axi_write(ADDR_CONFIG, {16'h0000, c}, 4'hF, r);
		axi_read(ADDR_CONFIG, d, r);
		check_word(d, {16'h0000, c}, "config readback");
	endtask

	// The output follows the pins three edges later: two synchroniser flops and one register.
	task automatic probe(input logic [15:0] c, input cal_t k);
		cal_i <= k;
		repeat (3) @(posedge clk);
		@(negedge clk);
		check_bit(timer_active, model(c, k), "timer active");
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		@(negedge clk);
		check_bit(timer_active, 1'b0, "active after reset");
		@(posedge clk);
		axi_read(ADDR_CONFIG, d, r);
		check_word(d, {16'h0000, CFG_RST}, "config reset value");
	endtask

	// A second reset in mid-run, with the timer active, must clear the output and the config.
	task automatic t_midreset();
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_reset();
	endtask

	task automatic t_days();
		cal_t        k;
		logic [15:0] c;
		for (int d = 0; d < 7; d++) begin
			c = 16'h0780 | (16'h0001 << d);
			set_cfg(c);
			for (int w = 0; w < 8; w++) begin
				k = '{weekday: w[2:0], season: 2'h2, holiday: 1'b0, workday: 1'b0, in_window: 1'b1};
				probe(c, k);
			end
		end
	endtask

	task automatic t_seasons();
		cal_t        k;
		logic [15:0] c;
		for (int s = 0; s < 4; s++) begin
			c = 16'h007F | (16'h0080 << s);
			set_cfg(c);
			for (int q = 0; q < 8; q++) begin
				k = '{weekday: 3'h4, season: q[1:0], holiday: 1'b0, workday: 1'b0, in_window: q[2]};
				probe(c, k);
			end
		end
	endtask

	// Every selection of bits 11 to 13 against every exception kind, on an enabled and on a
	// disabled weekday, in and out of the window; bits 14 and 15 are set throughout.
	task automatic t_exceptions();
		cal_t        k;
		logic [15:0] c;
		for (int m = 0; m < 8; m++) begin
			c = 16'hC081 | (16'(m) << 11);
			set_cfg(c);
			for (int j = 0; j < 16; j++) begin
				k = '{weekday: (j[3] ? 3'h6 : 3'h0), season: 2'h0, holiday: j[0], workday: j[1],
					in_window: j[2]};
				probe(c, k);
			end
		end
	endtask

	task automatic t_bus();
		logic [31:0] d;
		logic [1:0]  r;
		cal_t        k;
		set_cfg(16'h1234);
		axi_write(ADDR_CONFIG, 32'hFFFF_FFFF, 4'h1, r);
		axi_read(ADDR_CONFIG, d, r);
		check_word(d, 32'h0000_12FF, "low byte strobe");
		axi_write(32'h0000_0008, 32'h0000_0000, 4'hF, r);
		check_word({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write response");
		axi_read(32'h0000_0008, d, r);
		check_word(d, 32'h0000_0000, "unmapped read data");
		check_word({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read response");
		axi_write(ADDR_STATUS, 32'h0000_0000, 4'hF, r);
		check_word({30'h0, r}, {30'h0, RESP_OKAY}, "status write response");
		k = '{weekday: 3'h0, season: 2'h0, holiday: 1'b0, workday: 1'b0, in_window: 1'b1};
		probe(16'h12FF, k);
		axi_read(ADDR_STATUS, d, r);
		check_word(d, {23'h0, k, 1'b1}, "status word");
		axi_read(ADDR_CONFIG, d, r);
		check_word(d, 32'h0000_12FF, "config after status write");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		axil_i = '0;
		cal_i = '0;
		miscompares = 0;
		n_checks = 0;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_days();
		t_seasons();
		t_exceptions();
		t_bus();
		t_midreset();
		wrap_up();
	end

	// The tests need about a thousand cycles; this bound leaves ample margin.
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("mismatch at %0t: watchdog expired", $time);
		wrap_up();
	end

endmodule // calendar_timer_qualifier_bench
